/* File: bench/rtcu_checker.sv */
`timescale 1ns/100ps
module rtcu_checker
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [rtcu_pkg::INSTR_W-1:0] instr,
  input wire logic instr_valid,
  input wire logic [rtcu_pkg::DATA_W-1:0] file_rdata,
  input wire logic carry_in,
  input wire logic zero_in,
  input wire logic digit_carry_in,
  input wire logic [rtcu_pkg::ADDR_W-1:0] file_addr,
  input wire logic file_rd,
  input wire logic file_we,
  input wire logic [rtcu_pkg::DATA_W-1:0] file_wdata,
  input wire logic acc_we,
  input wire logic [rtcu_pkg::DATA_W-1:0] acc_wdata,
  input wire logic carry_we,
  input wire logic carry_out,
  input wire logic zero_out,
  input wire logic digit_carry_out,
  input wire logic busy
);
  import rtcu_pkg::*;
  logic [1:0] ph_reg, ph_next;
  logic q1, left, right, take;
  always_comb ph_next = ph_reg + 2'h1;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      ph_reg <= 2'h0;
    else
      ph_reg <= ph_next;
  assign q1 = ph_reg == 2'h0 && instr_valid;
  assign left = q1 && instr[OPC_HI:OPC_LO] == OPC_ROT_LEFT;
  assign right = q1 && instr[OPC_HI:OPC_LO] == OPC_ROT_RIGHT;
  assign take = left || right;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_steps;
    file_rd && busy ##1 (!file_rd && busy) [*2] ##1 !busy;
  endsequence
  property p_left;
    left |-> ##4 carry_we && carry_out == $past(file_rdata[7], 3)
      && acc_wdata == {$past(file_rdata[6:0], 3), $past(carry_in, 3)};
  endproperty
  a_left: assert property (p_left) else $error("left bad");
  property p_right;
    right |-> ##4 carry_we && carry_out == $past(file_rdata[0], 3)
      && acc_wdata == {$past(carry_in, 3), $past(file_rdata[7:1], 3)};
  endproperty
  a_right: assert property (p_right) else $error("right bad");
  property p_acc;
    take && !instr[DEST_BIT] |-> ##4 acc_we && !file_we;
  endproperty
  a_acc: assert property (p_acc) else $error("acc bad");
  property p_file;
    take && instr[DEST_BIT] |-> ##4 file_we && !acc_we
      && file_addr == $past(instr[6:0], 4);
  endproperty
  a_file: assert property (p_file) else $error("file bad");
  property p_steps;
    take |-> ##1 s_steps;
  endproperty
  a_steps: assert property (p_steps) else $error("steps bad");
  property p_flags;
    take |-> ##4 zero_out == $past(zero_in, 3)
      && digit_carry_out == $past(digit_carry_in, 3);
  endproperty
  a_flags: assert property (p_flags) else $error("flag bad");
  property p_quiet;
    (file_we || acc_we || carry_we) |-> $past(take, 4)
      && file_wdata == acc_wdata;
  endproperty
  a_quiet: assert property (p_quiet) else $error("stray write");
endmodule // rtcu_checker
bind rtcu_top rtcu_checker i_rtcu_checker (.*);

/* File: bench/rtcu_top_tb_top.sv */
`timescale 1ns/100ps
module rtcu_top_tb_top;
  import rtcu_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic instr_valid = 1'b0;
  logic [7:0] file_rdata = 8'h00;
  logic carry_in = 1'b0;
  logic zero_in = 1'b0;
  logic digit_carry_in = 1'b0;
  logic [6:0] file_addr;
  logic file_rd, file_we, acc_we, carry_we, carry_out, zero_out;
  logic digit_carry_out, busy;
  logic [7:0] file_wdata, acc_wdata;
  logic [1:0] ph = 2'h0;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  rtcu_top i_rtcu_top (.*);
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    ph <= rst_n ? ph + 2'h1 : 2'h0;
    cyc <= cyc + 1;
    if (cyc == 400)
    begin
      err_count++;
      end_sim;
    end
  end
  task automatic end_sim;
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // The phase is tracked here, so a word goes out on the edge before Q1.
  task automatic op(input logic [13:0] i, input logic v,
    input logic [7:0] d, input logic c, input logic [2:0] ew,
    input logic [7:0] ed, input logic ec);
    do @(posedge clk); while (ph != 2'h3);
    instr <= i;
    instr_valid <= v;
    file_rdata <= d;
    carry_in <= c;
    zero_in <= ~zero_in;
    digit_carry_in <= ~digit_carry_in;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    chk("file_rd", {7'h00, ew != 3'h0}, {7'h00, file_rd});
    chk("busy", {7'h00, ew != 3'h0}, {7'h00, busy});
    repeat (3) @(posedge clk);
    #1;
    chk("pulses", {5'h00, ew}, {5'h00, file_we, acc_we, carry_we});
    chk("busy end", 8'h00, {7'h00, busy});
    if (ew == 3'h0)
      return;
    chk("file_wdata", ed, file_wdata);
    chk("acc_wdata", ed, acc_wdata);
    chk("carry_out", {7'h00, ec}, {7'h00, carry_out});
    chk("file_addr", {1'b0, i[6:0]}, {1'b0, file_addr});
    chk("zero", {7'h00, zero_in}, {7'h00, zero_out});
    chk("dc", {7'h00, digit_carry_in}, {7'h00, digit_carry_out});
  endtask
  task automatic t_left;
    op({OPC_ROT_LEFT, 8'h25}, 1'b1, 8'he6, 1'b0, 3'h3, 8'hcc, 1'b1);
    op({OPC_ROT_LEFT, 8'h80}, 1'b1, 8'h80, 1'b1, 3'h5, 8'h01, 1'b1);
  endtask
  task automatic t_right;
    op({OPC_ROT_RIGHT, 8'hff}, 1'b1, 8'h01, 1'b1, 3'h5, 8'h80, 1'b1);
    op({OPC_ROT_RIGHT, 8'h11}, 1'b1, 8'hfe, 1'b0, 3'h3, 8'h7f, 1'b0);
  endtask
  // A reset in mid-instruction must drop the slot and lose the write.
  task automatic t_reset;
    do @(posedge clk); while (ph != 2'h3);
    instr <= {OPC_ROT_LEFT, 8'h80};
    instr_valid <= 1'b1;
    file_rdata <= 8'hff;
    @(posedge clk);
    instr_valid <= 1'b0;
    rst_n <= 1'b0;
    #1;
    chk("rst busy", 8'h00, {7'h00, busy});
    chk("rst file_rd", 8'h00, {7'h00, file_rd});
    chk("rst file_addr", 8'h00, {1'b0, file_addr});
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("rst pulses", 8'h00, {5'h00, file_we, acc_we, carry_we});
  endtask
  task automatic t_refused;
    op({6'h0e, 8'h80}, 1'b1, 8'h55, 1'b1, 3'h0, 8'h00, 1'b0);
    op({OPC_ROT_LEFT, 8'h80}, 1'b0, 8'h55, 1'b1, 3'h0, 8'h00, 1'b0);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_left;
    t_right;
    t_reset;
    t_refused;
    end_sim;
  end
endmodule // rtcu_top_tb_top

/* File: hw/rtcu_if.sv */
`timescale 1ns/100ps
interface rtcu_if;
  import rtcu_pkg::*;
  logic [DATA_W-1:0] operand;
  logic carry_in;
  rtcu_op_t op;
  logic [DATA_W-1:0] result;
  logic carry_out;
  modport core (output operand, output carry_in, output op,
    input result, input carry_out);
  modport shifter (input operand, input carry_in, input op,
    output result, output carry_out);
endinterface

/* File: hw/rtcu_pkg.sv */
package rtcu_pkg;
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int OPC_HI = 13;
  localparam int OPC_LO = 8;
  localparam int DEST_BIT = 7;
  localparam logic [5:0] OPC_ROT_LEFT = 6'h0d;
  localparam logic [5:0] OPC_ROT_RIGHT = 6'h0c;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [6:0] ADDR_RST = 7'h00;
  typedef enum logic [1:0] {
    RTCU_OP_NONE,
    RTCU_OP_LEFT,
    RTCU_OP_RIGHT
  } rtcu_op_t;
  typedef enum {
    RTCU_Q1,
    RTCU_Q2,
    RTCU_Q3,
    RTCU_Q4
  } rtcu_phase_t;
endpackage

/* File: hw/rtcu_shifter.sv */
`timescale 1ns/100ps
module rtcu_shifter
(
  rtcu_if.shifter sif
);
  import rtcu_pkg::*;
  always_comb
  begin
    sif.result = sif.operand;
    sif.carry_out = sif.carry_in;
    unique case (sif.op)
      RTCU_OP_LEFT:
      begin
        sif.result = {sif.operand[DATA_W-2:0], sif.carry_in};
        sif.carry_out = sif.operand[DATA_W-1];
      end
      RTCU_OP_RIGHT:
      begin
        sif.result = {sif.carry_in, sif.operand[DATA_W-1:1]};
        sif.carry_out = sif.operand[0];
      end
      RTCU_OP_NONE:
      begin
        sif.result = sif.operand;
        sif.carry_out = sif.carry_in;
      end
    endcase
  end
endmodule // rtcu_shifter

/* File: hw/rtcu_top.sv */
`timescale 1ns/100ps
module rtcu_top
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [rtcu_pkg::INSTR_W-1:0] instr,
  input wire logic instr_valid,
  input wire logic [rtcu_pkg::DATA_W-1:0] file_rdata,
  input wire logic carry_in,
  input wire logic zero_in,
  input wire logic digit_carry_in,
  output logic [rtcu_pkg::ADDR_W-1:0] file_addr,
  output logic file_rd,
  output logic file_we,
  output logic [rtcu_pkg::DATA_W-1:0] file_wdata,
  output logic acc_we,
  output logic [rtcu_pkg::DATA_W-1:0] acc_wdata,
  output logic carry_we,
  output logic carry_out,
  output logic zero_out,
  output logic digit_carry_out,
  output logic busy
);
  import rtcu_pkg::*;

  rtcu_if sif ();
  rtcu_shifter u_shifter (.sif(sif));

  rtcu_phase_t phase_reg, phase_next;
  rtcu_op_t op_reg, op_next;
  logic dest_reg, dest_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] operand_reg, operand_next;
  logic [DATA_W-1:0] result_reg, result_next;
  logic cy_reg, cy_next;
  logic rd_reg, rd_next;
  logic fwe_reg, fwe_next;
  logic awe_reg, awe_next;
  logic cwe_reg, cwe_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic z_reg, z_next;
  logic dc_reg, dc_next;
  logic busy_reg, busy_next;
  rtcu_op_t dec_op;
  logic dec_hit;

  // Anything that is not a rotate decodes as no operation and never writes.
  always_comb
  begin
    dec_op = RTCU_OP_NONE;
    if (instr[OPC_HI:OPC_LO] == OPC_ROT_LEFT)
      dec_op = RTCU_OP_LEFT;
    else if (instr[OPC_HI:OPC_LO] == OPC_ROT_RIGHT)
      dec_op = RTCU_OP_RIGHT;
  end

  // A word only counts when it is valid and decodes as a rotate.
  assign dec_hit = instr_valid && (dec_op != RTCU_OP_NONE);

  assign sif.operand = operand_reg;
  assign sif.carry_in = cy_reg;
  assign sif.op = op_reg;

  // The four phases always run, so any instruction gets a fixed slot.
  // Phase, decode and the read strobe form the sequencer group.
  always_comb
  begin
    phase_next = phase_reg;
    op_next = op_reg;
    dest_next = dest_reg;
    addr_next = addr_reg;
    rd_next = 1'b0;
    busy_next = busy_reg;
    unique case (phase_reg)
      RTCU_Q1:
      begin
        phase_next = RTCU_Q2;
        op_next = instr_valid ? dec_op : RTCU_OP_NONE;
        dest_next = instr[DEST_BIT];
        addr_next = instr[ADDR_W-1:0];
        busy_next = dec_hit;
        rd_next = dec_hit;
      end
      RTCU_Q2:
      begin
        phase_next = RTCU_Q3;
      end
      RTCU_Q3:
      begin
        phase_next = RTCU_Q4;
      end
      RTCU_Q4:
      begin
        // Busy drops at the write edge, so it never overlaps the write strobes.
        phase_next = RTCU_Q1;
        busy_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_reg <= RTCU_Q1;
      op_reg <= RTCU_OP_NONE;
      dest_reg <= 1'b0;
      addr_reg <= ADDR_RST;
      rd_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_next;
      op_reg <= op_next;
      dest_reg <= dest_next;
      addr_reg <= addr_next;
      rd_reg <= rd_next;
      busy_reg <= busy_next;
    end
  end

  // Flags are caught with the operand, so all of them share one instant.
  always_comb
  begin
    operand_next = operand_reg;
    result_next = result_reg;
    cy_next = cy_reg;
    z_next = z_reg;
    dc_next = dc_reg;
    unique case (phase_reg)
      RTCU_Q2:
      begin
        operand_next = file_rdata;
        cy_next = carry_in;
        z_next = zero_in;
        dc_next = digit_carry_in;
      end
      RTCU_Q3:
      begin
        result_next = sif.result;
        cy_next = sif.carry_out;
      end
      // Decode and write phases leave the datapath alone.
      RTCU_Q1, RTCU_Q4:
      begin
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      operand_reg <= DATA_RST;
      result_reg <= DATA_RST;
      cy_reg <= 1'b0;
      z_reg <= 1'b0;
      dc_reg <= 1'b0;
    end
    else
    begin
      operand_reg <= operand_next;
      result_reg <= result_next;
      cy_reg <= cy_next;
      z_reg <= z_next;
      dc_reg <= dc_next;
    end
  end

  // Strobes last one clock, so the storage side needs no edge detector.
  // The destination bit makes the two data strobes exclusive.
  always_comb
  begin
    fwe_next = 1'b0;
    awe_next = 1'b0;
    cwe_next = 1'b0;
    wdata_next = wdata_reg;
    if (phase_reg == RTCU_Q4 && op_reg != RTCU_OP_NONE)
    begin
      wdata_next = result_reg;
      cwe_next = 1'b1;
      fwe_next = dest_reg;
      awe_next = !dest_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fwe_reg <= 1'b0;
      awe_reg <= 1'b0;
      cwe_reg <= 1'b0;
      wdata_reg <= DATA_RST;
    end
    else
    begin
      fwe_reg <= fwe_next;
      awe_reg <= awe_next;
      cwe_reg <= cwe_next;
      wdata_reg <= wdata_next;
    end
  end

  // Every output is a register, so no decode glitch reaches a pin.
  assign file_addr = addr_reg;
  assign file_rd = rd_reg;
  assign file_we = fwe_reg;
  assign file_wdata = wdata_reg;
  assign acc_we = awe_reg;
  assign acc_wdata = wdata_reg;
  assign carry_we = cwe_reg;
  assign carry_out = cy_reg;
  assign zero_out = z_reg;
  assign digit_carry_out = dc_reg;
  assign busy = busy_reg;
endmodule // rtcu_top
